// ---- core/cfm_pkg.sv ----
/*
  Shared constants for the CAN transceiver fault monitor: mode encodings,
  mode-bit positions and default time-out counts.
  Assumes a 250 MHz core clock (4 ns period).
*/
package cfm_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Time-out figures are not fixed by the device; these are plain defaults in microseconds.
  localparam int unsigned TX_TIMEOUT_US = 1000;
  localparam int unsigned BUS_TIMEOUT_US = 2000;
  localparam int unsigned TX_TIMEOUT_CYC = (TX_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned BUS_TIMEOUT_CYC = (BUS_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 24;
  typedef enum logic [1:0] {
    CFM_MODE_OFF = 2'h0,
    CFM_MODE_WAKE = 2'h1,
    CFM_MODE_RX_ONLY = 2'h2,
    CFM_MODE_NORMAL = 2'h3
  } cfm_mode_t;
  localparam int unsigned MODE_UV_EN_BIT = 1;
  localparam int unsigned MODE_TX_BIT = 0;
endpackage

// ---- core/cfm_dom_timer.sv ----
/*
  Dominant-time filter: counts cycles while a monitored level stays dominant
  and raises a level once the terminal count is passed.
  Assumes its input is already synchronous to mclk.
*/
`timescale 1ns/1ps
module cfm_dom_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned CNT_W = 24
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic dominant,
  output logic expired
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_expired;

  // Restart whenever the level returns recessive or monitoring is off.
  always_comb begin
    next_count = count;
    next_expired = expired;
    if (!enable || !dominant) begin
      next_count = '0;
      next_expired = 1'b0;
    end else if (count >= CNT_W'(LIMIT)) begin
      next_expired = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      expired <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      expired <= next_expired;
    end
  end
endmodule

// ---- core/cfm_monitor.sv ----
/*
  Fault supervision for a high-speed CAN transceiver: transmit-dominant
  time-out, bus-dominant clamping detection and supply undervoltage handling,
  with sticky fault flags cleared by software.
  Assumes pins (transmit input, bus level, undervoltage comparator) are
  asynchronous and are synchronised here; mode and clear come from mclk logic.
  Active low on the transmit and receive pins means dominant.
*/
// Notes on behaviour
// - Normal mode: transmit dominant past time-out forces driver recessive.
// - Transmit time-out keeps mode bits unchanged and sets bus fault flag.
// - Once transmit input goes recessive, transmitter resumes automatically.
// - Normal or receive-only: bus dominant past its time-out sets bus fault.
// - Bus clamping leaves the programmed configuration untouched.
// - Bus clamping time-out is strictly longer than transmit time-out.
// - Supply undervoltage is monitored only in normal or receive-only mode.
// - Undervoltage sets its flag and disables the transmitter.
// - Supply above release threshold re-enables transmitter automatically.
// - Undervoltage detection enabled exactly when upper mode bit is one.
// - Wake-capable mode is encoded as 01.
// - Receive-only keeps driver off yet still forwards bus levels.
`timescale 1ns/1ps
module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int unsigned TX_LIMIT = cfm_pkg::TX_TIMEOUT_CYC,
  parameter int unsigned BUS_LIMIT = cfm_pkg::BUS_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire cfm_pkg::cfm_mode_t mode,
  input wire logic txd_n,
  input wire logic bus_rx_n,
  input wire logic supply_uv,
  input wire logic bus_fault_clr,
  input wire logic uv_flag_clr,
  output logic drive_dominant,
  output logic driver_en,
  output logic rxd_n,
  output logic bus_fault_flag,
  output logic transceiver_supply_undervoltage_flag,
  output logic tx_timed_out
);
  import cfm_pkg::*;

  logic txd_meta, txd_s, bus_meta, bus_s, uv_meta, uv_s;
  logic tx_exp, bus_exp;
  logic next_drive_dominant, next_driver_en, next_rxd_n;
  logic next_bus_fault_flag, next_uv_flag, next_tx_timed_out;
  logic uv_active, tx_mode;

  // Two-stage synchronisers; only the second stage is read.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txd_meta <= 1'b1;
      txd_s <= 1'b1;
      bus_meta <= 1'b1;
      bus_s <= 1'b1;
      uv_meta <= 1'b0;
      uv_s <= 1'b0;
    end else if (ce) begin
      txd_meta <= txd_n;
      txd_s <= txd_meta;
      bus_meta <= bus_rx_n;
      bus_s <= bus_meta;
      uv_meta <= supply_uv;
      uv_s <= uv_meta;
    end
  end

  // Undervoltage gating follows the upper mode bit alone.
  assign uv_active = mode[MODE_UV_EN_BIT] & uv_s;
  // Only 11 drives; 10 is receive-only and 01 wake-capable.
  assign tx_mode = (mode == CFM_MODE_NORMAL);

  cfm_dom_timer #(.LIMIT(TX_LIMIT), .CNT_W(CNT_W)) u_tx_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .enable(tx_mode),
    .dominant(!txd_s),
    .expired(tx_exp)
  );

  cfm_dom_timer #(.LIMIT(BUS_LIMIT), .CNT_W(CNT_W)) u_bus_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .enable(mode[MODE_UV_EN_BIT]),
    .dominant(!bus_s),
    .expired(bus_exp)
  );

  always_comb begin
    // Time-out and undervoltage block only the driver; mode is an input
    // and is never written here.
    next_tx_timed_out = tx_exp;
    next_driver_en = tx_mode && !tx_exp && !uv_active;
    next_drive_dominant = next_driver_en && !txd_s;
    // Received level is forwarded in normal and receive-only modes.
    next_rxd_n = mode[MODE_UV_EN_BIT] ? bus_s : 1'b1;
    // Set wins over a same-cycle clear.
    next_bus_fault_flag = (bus_fault_flag && !bus_fault_clr) || tx_exp || bus_exp;
    next_uv_flag = (transceiver_supply_undervoltage_flag && !uv_flag_clr) || uv_active;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      drive_dominant <= 1'b0;
      driver_en <= 1'b0;
      rxd_n <= 1'b1;
      bus_fault_flag <= 1'b0;
      transceiver_supply_undervoltage_flag <= 1'b0;
      tx_timed_out <= 1'b0;
    end else if (ce) begin
      drive_dominant <= next_drive_dominant;
      driver_en <= next_driver_en;
      rxd_n <= next_rxd_n;
      bus_fault_flag <= next_bus_fault_flag;
      transceiver_supply_undervoltage_flag <= next_uv_flag;
      tx_timed_out <= next_tx_timed_out;
    end
  end

  // Clamping filter must outlast the transmit filter.
  initial begin
    a_limit_order: assert (BUS_LIMIT > TX_LIMIT) else $error("bus limit not above tx limit");
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_tx_expired;
    ce && tx_exp;
  endsequence

  // Recovery is only owed once the filter itself has dropped, not on the
  // first recessive sample, which still sees the expired level.
  sequence s_tx_clear;
    ce && tx_mode && txd_s && !tx_exp && !uv_active;
  endsequence

  // A clean normal-mode dominant request with no fault pending.
  sequence s_tx_request;
    ce && tx_mode && !txd_s && !tx_exp && !uv_active;
  endsequence

  sequence s_bus_clamped;
    ce && bus_exp;
  endsequence

  a_tx_recessive: assert property (s_tx_expired |=> !drive_dominant)
    else $error("driver dominant after transmit time-out");
  a_tx_flag_set: assert property (s_tx_expired |=> bus_fault_flag)
    else $error("bus fault flag not set on time-out");
  a_tx_resume: assert property (s_tx_clear |=> driver_en)
    else $error("transmitter not resumed");
  a_bus_clamp: assert property (s_bus_clamped |=> bus_fault_flag)
    else $error("clamp not flagged");

  // The time-out level is reported while it holds and dropped once cleared.
  a_tx_level_out: assert property (s_tx_expired |=> tx_timed_out)
    else $error("time-out level not reported");
  a_tx_level_clear: assert property (ce && !tx_exp |=> !tx_timed_out)
    else $error("time-out level stuck");
  a_tx_drive: assert property (s_tx_request |=> drive_dominant && driver_en)
    else $error("dominant request not driven");
  a_tx_gate: assert property (ce && !tx_mode |=> !tx_exp)
    else $error("transmit filter ran outside normal mode");

  // Clamping is reported only; the driver keeps its programmed state.
  a_clamp_keep: assert property (s_bus_clamped && !tx_exp && !uv_active && tx_mode |=> driver_en)
    else $error("clamping disturbed the driver");
  a_bus_gate: assert property (ce && !mode[MODE_UV_EN_BIT] |=> !bus_exp)
    else $error("bus filter ran outside monitored modes");

  a_uv_drive_off: assert property (ce && uv_active |=> !drive_dominant)
    else $error("driving during undervoltage");
  a_uv_sticky: assert property (ce && transceiver_supply_undervoltage_flag && !uv_flag_clr |=> transceiver_supply_undervoltage_flag)
    else $error("undervoltage flag lost");
  a_uv_clear: assert property (ce && uv_flag_clr && !uv_active |=> !transceiver_supply_undervoltage_flag)
    else $error("undervoltage flag not cleared");
  a_bus_clear: assert property (ce && bus_fault_clr && !tx_exp && !bus_exp |=> !bus_fault_flag)
    else $error("bus fault flag not cleared");

  // Outside the transmit mode the driver must stay off whatever the pin does.
  a_mode_off: assert property (ce && !tx_mode |=> !driver_en && !drive_dominant)
    else $error("driver active outside normal mode");
  a_wake_rxd: assert property (ce && !mode[MODE_UV_EN_BIT] |=> rxd_n)
    else $error("receive output not recessive");

  // A low enable must freeze the bus fault flag, driver enable and receive output.
  a_ce_freeze: assert property (!ce |=> $stable(bus_fault_flag) && $stable(driver_en) && $stable(rxd_n))
    else $error("state moved with clock enable low");
  a_uv_flag: assert property (ce && uv_active |=> transceiver_supply_undervoltage_flag && !driver_en)
    else $error("undervoltage not handled");
  a_uv_gate: assert property (ce && !mode[MODE_UV_EN_BIT] && !transceiver_supply_undervoltage_flag ##1 ce && !mode[MODE_UV_EN_BIT] |-> !transceiver_supply_undervoltage_flag)
    else $error("undervoltage flagged outside monitored modes");
  a_rxonly_off: assert property (ce && mode == CFM_MODE_RX_ONLY |=> !driver_en && rxd_n == $past(bus_s))
    else $error("receive-only misbehaves");
  a_flag_sticky: assert property (ce && bus_fault_flag && !bus_fault_clr |=> bus_fault_flag)
    else $error("bus fault flag lost");
endmodule

// ---- testbench/cfm_bus_model.sv ----
/*
  Far-side model: the CAN bus seen as a wired-AND of this node and the rest.
  Assumes the monitor's driver outputs and a bench-driven foreign node level.
*/
`timescale 1ns/1ps
module cfm_bus_model (
  input wire logic drive_dominant,
  input wire logic driver_en,
  input wire logic other_dom,
  output logic bus_rx_n
);
  // A disabled driver cannot pull the bus, whatever drive_dominant says.
  assign bus_rx_n = !((drive_dominant && driver_en) || other_dom);
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the fault monitor, run with shortened time-outs.
  Assumes the bus model closes the loop from driver outputs to bus level.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  import cfm_pkg::*;
  localparam int TXL = 8;
  localparam int BXL = 16;
  logic mclk = 0, arst_n = 0, ce = 1, txd_n = 1, oth = 0, uv = 0, clr = 0;
  logic dd, en, rxd_n, bf, uvf, tto, bus_n;
  cfm_mode_t mode = CFM_MODE_OFF;
  int n_fail = 0, n_compared = 0, cyc = 0;
  // Row: mode, txd_n, other node, uv, clear after check, wait, {drive, en, rxd_n, bf, uvf}.
  logic [15:0] rows [12] = '{16'he4cc, 16'hc0d8, 16'hc186, 16'he4ce, 16'hf188, 16'hf18a,
    16'hb702, 16'had07, 16'hc8c5, 16'he4cd, 16'h7a84, 16'h20c4};
  always #2 mclk = ~mclk;
  cfm_bus_model cfm_bus_model_inst (
    .drive_dominant(dd),
    .driver_en(en),
    .other_dom(oth),
    .bus_rx_n(bus_n)
  );
  cfm_monitor #(.TX_LIMIT(TXL), .BUS_LIMIT(BXL)) cfm_monitor_inst (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .mode(mode),
    .txd_n(txd_n),
    .bus_rx_n(bus_n),
    .supply_uv(uv),
    .bus_fault_clr(clr),
    .uv_flag_clr(clr),
    .drive_dominant(dd),
    .driver_en(en),
    .rxd_n(rxd_n),
    .bus_fault_flag(bf),
    .transceiver_supply_undervoltage_flag(uvf),
    .tx_timed_out(tto)
  );
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(negedge mclk);
    `CHK("reset", 6'h08, {dd & en, en, rxd_n, bf, uvf, tto})
    arst_n = 1;
    for (int i = 0; i < 12; i++) begin
      mode = cfm_mode_t'(rows[i][15:14]);
      {txd_n, oth, uv} = rows[i][13:11];
      repeat (rows[i][9:5]) @(negedge mclk);
      `CHK("row", rows[i][4:0], {dd & en, en, rxd_n, bf, uvf})
      if (rows[i][10]) begin
        clr = 1;
        @(negedge mclk);
        clr = 0;
      end
    end
    mode = CFM_MODE_NORMAL;
    repeat (4) @(negedge mclk);
    txd_n = 0;
    repeat (TXL + 2) @(negedge mclk);
    `CHK("tx_early", 1'h0, tto)
    repeat (3) @(negedge mclk);
    `CHK("tx_late", 1'h1, tto)
    arst_n = 0;
    #1;
    `CHK("mid_reset", 6'h08, {dd & en, en, rxd_n, bf, uvf, tto})
    ce = 0;
    @(negedge mclk);
    arst_n = 1;
    repeat (30) @(negedge mclk);
    `CHK("ce_hold", 1'h0, tto)
    ce = 1;
    repeat (TXL + 6) @(negedge mclk);
    `CHK("ce_run", 1'h1, tto)
    summarize();
  end
endmodule
